/* rtl/power_monitor_pkg.sv */
// shared constants, register layout and types of the power monitor readback
// assumes an i2c byte engine outside decodes addresses and command bytes
package power_monitor_pkg;

  // -------------------------------------------------------------
  // clock and timing
  // -------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;          // 125 MHz system clock
  localparam int TRIP_DELAY_CYCLES = 1000;   // default fault delay length

  // -------------------------------------------------------------
  // extended register indices (low two bits of the address byte)
  // -------------------------------------------------------------
  localparam logic [1:0] EXT_ALARM_ENABLE = 2'h1;
  localparam logic [1:0] EXT_CURRENT_ALARM_THRESHOLD = 2'h2;
  localparam logic [1:0] EXT_FORCE_OFF_CONTROL = 2'h3;

  // -------------------------------------------------------------
  // reset values
  // -------------------------------------------------------------
  localparam logic [7:0] ALARM_ENABLE_RST = 8'h04;
  localparam logic [7:0] THRESHOLD_RST = 8'hff;  // adc full scale
  localparam logic [7:0] FORCE_OFF_CONTROL_RST = 8'h00;
  localparam logic [7:0] COMMAND_RST = 8'h00;

  // -------------------------------------------------------------
  // command byte fields
  // -------------------------------------------------------------
  localparam int CMD_VOLTAGE_CONTINUOUS = 0;
  localparam int CMD_VOLTAGE_ONCE = 1;
  localparam int CMD_CURRENT_CONTINUOUS = 2;
  localparam int CMD_CURRENT_ONCE = 3;
  localparam int CMD_STATUS_READ = 6;

  // -------------------------------------------------------------
  // alarm enable fields
  // -------------------------------------------------------------
  localparam int EN_CONV_SINGLE = 0;
  localparam int EN_CONV_FOUR = 1;
  localparam int EN_LATCHED_OC = 2;
  localparam int EN_FORCE_OFF = 3;
  localparam int EN_CLEAR = 4;

  // -------------------------------------------------------------
  // force-off control and status fields
  // -------------------------------------------------------------
  localparam int CTL_SOFTWARE_FORCE_OFF = 0;
  localparam int ST_CONV_OVERCURRENT_SEEN = 0;
  localparam int ST_CONV_ALARM = 1;
  localparam int ST_COMPARATOR_OVERCURRENT = 2;
  localparam int ST_LATCHED_OVERCURRENT_ALARM = 3;
  localparam int ST_FORCE_OFF_STATUS = 4;
  localparam int ST_FORCE_OFF_ALARM = 5;

  // -------------------------------------------------------------
  // types
  // -------------------------------------------------------------
  typedef enum logic [1:0] {
    RB_COMBINED = 2'b00,
    RB_VOLTAGE = 2'b01,
    RB_CURRENT = 2'b10,
    RB_STATUS = 2'b11
  } readback_mode_t;

  typedef enum logic {
    SEQ_IDLE = 1'b0,
    SEQ_SEND = 1'b1
  } seq_state_t;

  typedef struct packed {
    logic [7:0] data;  // byte for the master
    logic last;        // final byte of this read
  } read_byte_t;

  typedef struct packed {
    logic ext;         // extended register write, else command byte
    logic [1:0] addr;  // extended register index
    logic [7:0] data;  // written value
  } cfg_write_t;

endpackage

/* rtl/two_entry_buffer.sv */
// two-entry valid/ready buffer with registered read data
// assumes both sides share clk_sys; flush drops whatever is held
module two_entry_buffer #(
  parameter int WIDTH = 9
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic flush,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  // -------------------------------------------------------------
  // storage: head register feeds the output, tail holds the spare
  // -------------------------------------------------------------
  logic [WIDTH-1:0] head_ff;  // word on the output
  logic [WIDTH-1:0] tail_ff;  // second word while the drain stalls
  logic [1:0] count_ff;       // words held, 0..2
  logic push;
  logic pop;

  assign inReady = (count_ff != 2'h2);
  assign outValid = (count_ff != 2'h0);
  assign outData = head_ff;
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  // occupancy count
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      count_ff <= 2'h0;
    end else if (flush) begin
      count_ff <= 2'h0;
    end else begin
      count_ff <= count_ff + {1'b0, push} - {1'b0, pop};
    end
  end

  // head takes the new word when empty or when its one word pops; otherwise a pop moves the tail up
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      head_ff <= '0;
      tail_ff <= '0;
    end else begin
      if (push && (count_ff == 2'h0 || (count_ff == 2'h1 && pop))) begin
        head_ff <= inData;
      end else if (pop) begin
        head_ff <= tail_ff;
      end
      // a word lands in the tail only behind an occupied head
      if (push && (count_ff == 2'h2 || (count_ff == 2'h1 && !pop))) begin
        tail_ff <= inData;
      end
    end
  end

endmodule

/* rtl/power_monitor_readback_alert.sv */
// readback, status and alarm logic of a current/voltage monitor
// assumes an i2c byte engine outside: it hands in decoded register writes,
// signals read starts and stops, and shifts out the bytes offered here

// Overview of operation
// - 8-bit threshold checks current top eight bits
// - force-off deasserts alarm while its enable high
// - combined read returns three packed bytes
// - voltage-only read returns two bytes, zero nibble
// - current-only read returns two bytes, zero nibble
// - single-channel reads hold exactly two bytes
// - status read returns one status byte
// - status bit0: last three conversions overcurrent
// - status bit1 sticky conversion-based alarm
// - status bit2 mirrors live trip comparator
// - status bit3 sticky latched comparator alarm
// - status bit4 set by writing force-off
// - status bit5 sticky force-off alarm
// - clear bit write clears bits 1,3,5
// - alarm low normally, high on fault
// - comparator starts delay, alarm after delay
// - early continuous read acked, returns zeros
// - single-shot self-clears, reads nacked until done
// - clear self-clears; causes may set again
module power_monitor_readback_alert #(
  parameter int TRIP_DELAY = power_monitor_pkg::TRIP_DELAY_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // decoded register writes from the bus engine
  input wire logic cfgValid,
  input wire power_monitor_pkg::cfg_write_t cfgWrite,
  // conversion results from the adc
  input wire logic convValid,
  input wire logic convIsCurrent,
  input wire logic [11:0] convCode,
  // trip-level comparator, high while amplifier exceeds trip input
  input wire logic tripCompAbove,
  // conversion requests to the adc
  output logic voltageContinuous,
  output logic currentContinuous,
  output logic voltageOncePending,
  output logic currentOncePending,
  // read transaction from the bus engine
  input wire logic rdStart,
  input wire logic rdStop,
  output logic rdAckValid,
  output logic rdAckYes,
  // read byte stream toward the bus engine
  output logic byteValid,
  input wire logic byteReady,
  output power_monitor_pkg::read_byte_t byteOut,
  // open-drain alarm pin, driven low when quiet
  output logic alarmOut,
  output logic alarmOe,
  input wire logic alarmIn
);

  // -------------------------------------------------------------
  // configuration registers
  // -------------------------------------------------------------
  localparam int TW = $clog2(TRIP_DELAY + 1);
  localparam logic [TW-1:0] TRIP_MAX = TW'(TRIP_DELAY - 1);

  logic [7:0] command_ff;        // mode bits of the command byte
  logic [3:0] alarmEnable_ff;    // enable bits, clear bit is not stored
  logic [7:0] threshold_ff;      // current_alarm_threshold
  logic softwareForceOff_ff;     // force-off control bit
  logic [1:0] chanSel_ff;        // channels chosen: bit 0 voltage, 1 current

  wire cmdWrite = cfgValid && !cfgWrite.ext;
  wire enWrite = cfgValid && cfgWrite.ext &&
                 cfgWrite.addr == power_monitor_pkg::EXT_ALARM_ENABLE;
  wire thrWrite = cfgValid && cfgWrite.ext &&
                  cfgWrite.addr ==
                  power_monitor_pkg::EXT_CURRENT_ALARM_THRESHOLD;
  wire ctlWrite = cfgValid && cfgWrite.ext &&
                  cfgWrite.addr == power_monitor_pkg::EXT_FORCE_OFF_CONTROL;
  // clear acts for one cycle only, so it reads back as self-cleared
  wire clearPulse = enWrite &&
                    cfgWrite.data[power_monitor_pkg::EN_CLEAR];

  wire voltDone = convValid && !convIsCurrent;
  wire currDone = convValid && convIsCurrent;

  // register writes; single-shot bits drop when their conversion lands
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      command_ff <= power_monitor_pkg::COMMAND_RST;
      chanSel_ff <= 2'h0;
      alarmEnable_ff <= power_monitor_pkg::ALARM_ENABLE_RST[3:0];
      threshold_ff <= power_monitor_pkg::THRESHOLD_RST;
      softwareForceOff_ff <= power_monitor_pkg::FORCE_OFF_CONTROL_RST[0];
    end else begin
      if (cmdWrite) begin
        command_ff <= cfgWrite.data;
        // kept apart from the shot bits, which drop once the result lands
        chanSel_ff <= {
          cfgWrite.data[power_monitor_pkg::CMD_CURRENT_CONTINUOUS] ||
            cfgWrite.data[power_monitor_pkg::CMD_CURRENT_ONCE],
          cfgWrite.data[power_monitor_pkg::CMD_VOLTAGE_CONTINUOUS] ||
            cfgWrite.data[power_monitor_pkg::CMD_VOLTAGE_ONCE]};
      end else begin
        if (voltDone) command_ff[power_monitor_pkg::CMD_VOLTAGE_ONCE] <= 1'b0;
        if (currDone) command_ff[power_monitor_pkg::CMD_CURRENT_ONCE] <= 1'b0;
      end
      if (enWrite) alarmEnable_ff <= cfgWrite.data[3:0];
      if (thrWrite) threshold_ff <= cfgWrite.data;
      if (ctlWrite) begin
        softwareForceOff_ff <=
          cfgWrite.data[power_monitor_pkg::CTL_SOFTWARE_FORCE_OFF];
      end
    end
  end

  assign voltageContinuous =
    command_ff[power_monitor_pkg::CMD_VOLTAGE_CONTINUOUS];
  assign currentContinuous =
    command_ff[power_monitor_pkg::CMD_CURRENT_CONTINUOUS];
  assign voltageOncePending = command_ff[power_monitor_pkg::CMD_VOLTAGE_ONCE];
  assign currentOncePending = command_ff[power_monitor_pkg::CMD_CURRENT_ONCE];
  wire oncePending = voltageOncePending || currentOncePending;

  // -------------------------------------------------------------
  // conversion results and threshold history
  // -------------------------------------------------------------
  logic [11:0] voltData_ff;  // zero until the first conversion
  logic [11:0] currData_ff;
  logic [3:0] overHist_ff;   // newest comparison in bit 0

  wire currOver = convCode[11:4] > threshold_ff;

  // results start at zero so an early read returns zeros
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      voltData_ff <= 12'h000;
      currData_ff <= 12'h000;
      overHist_ff <= 4'h0;
    end else begin
      if (voltDone) voltData_ff <= convCode;
      if (currDone) begin
        currData_ff <= convCode;
        overHist_ff <= {overHist_ff[2:0], currOver};
      end
    end
  end

  // -------------------------------------------------------------
  // fault delay standing in for the timer capacitor
  // -------------------------------------------------------------
  logic [TW-1:0] tripCnt_ff;  // cycles the comparator has stayed high
  wire timerDone = tripCompAbove && tripCnt_ff == TRIP_MAX;

  // restarts from zero whenever the comparator falls before the end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tripCnt_ff <= '0;
    end else if (!tripCompAbove) begin
      tripCnt_ff <= '0;
    end else if (tripCnt_ff != TRIP_MAX) begin
      tripCnt_ff <= tripCnt_ff + TW'(1);
    end
  end

  // -------------------------------------------------------------
  // sticky status flags
  // -------------------------------------------------------------
  logic convAlarm_ff;      // conversion-based alarm
  logic latchedOcAlarm_ff; // latched_overcurrent_alarm
  logic forceOffAlarm_ff;  // alarm raised by force-off

  wire forceOffActive = softwareForceOff_ff &&
                        alarmEnable_ff[power_monitor_pkg::EN_FORCE_OFF];
  wire convAlarmSet = currDone &&
    ((alarmEnable_ff[power_monitor_pkg::EN_CONV_SINGLE] && currOver) ||
     (alarmEnable_ff[power_monitor_pkg::EN_CONV_FOUR] && currOver &&
      &overHist_ff[2:0]));
  wire ocAlarmSet = timerDone &&
                    alarmEnable_ff[power_monitor_pkg::EN_LATCHED_OC];

  // a set in the clearing cycle wins, so no event is lost
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      convAlarm_ff <= 1'b0;
      latchedOcAlarm_ff <= 1'b0;
      forceOffAlarm_ff <= 1'b0;
    end else begin
      convAlarm_ff <= (convAlarm_ff && !clearPulse) || convAlarmSet;
      latchedOcAlarm_ff <= (latchedOcAlarm_ff && !clearPulse) || ocAlarmSet;
      forceOffAlarm_ff <= (forceOffAlarm_ff && !clearPulse) || forceOffActive;
    end
  end

  // live status byte; reserved upper bits read zero
  wire [7:0] statusLive = {
    2'b00,
    forceOffAlarm_ff,
    softwareForceOff_ff,
    latchedOcAlarm_ff,
    tripCompAbove,
    convAlarm_ff,
    &overHist_ff[2:0]
  };

  // -------------------------------------------------------------
  // alarm pin
  // -------------------------------------------------------------
  // force-off overrides every fault while its enable is set
  wire alarmDrive = (convAlarm_ff || latchedOcAlarm_ff) &&
                    !forceOffActive;
  // open drain: pull low when quiet, release so the pull-up lifts it
  assign alarmOut = 1'b0;
  assign alarmOe = !alarmDrive;

  // -------------------------------------------------------------
  // readback sequencer
  // -------------------------------------------------------------
  power_monitor_pkg::seq_state_t state_ff;
  power_monitor_pkg::readback_mode_t mode_ff;
  logic [1:0] byteIdx_ff;
  logic [11:0] snapV_ff;  // values frozen at the read start
  logic [11:0] snapI_ff;
  logic [7:0] snapS_ff;
  logic ackValid_ff;
  logic ackYes_ff;
  logic bufInReady;
  logic bufOutValid;

  // format follows the last command, so a read after a shot keeps it
  wire vSel = chanSel_ff[0];
  wire iSel = chanSel_ff[1];
  wire power_monitor_pkg::readback_mode_t modeNow =
    command_ff[power_monitor_pkg::CMD_STATUS_READ] ?
      power_monitor_pkg::RB_STATUS :
    (vSel && !iSel) ? power_monitor_pkg::RB_VOLTAGE :
    (iSel && !vSel) ? power_monitor_pkg::RB_CURRENT :
      power_monitor_pkg::RB_COMBINED;

  // bytes a read of each mode carries
  function automatic logic [1:0] byte_total(
    input power_monitor_pkg::readback_mode_t m
  );
    unique case (m)
      power_monitor_pkg::RB_COMBINED: byte_total = 2'd3;
      power_monitor_pkg::RB_VOLTAGE: byte_total = 2'd2;
      power_monitor_pkg::RB_CURRENT: byte_total = 2'd2;
      power_monitor_pkg::RB_STATUS: byte_total = 2'd1;
    endcase
  endfunction

  // byte packing per mode and position
  function automatic logic [7:0] pick_byte(
    input power_monitor_pkg::readback_mode_t m,
    input logic [1:0] idx,
    input logic [11:0] v,
    input logic [11:0] i,
    input logic [7:0] s
  );
    unique case (m)
      power_monitor_pkg::RB_COMBINED: begin
        pick_byte = (idx == 2'd0) ? v[11:4] :
                    (idx == 2'd1) ? i[11:4] : {v[3:0], i[3:0]};
      end
      power_monitor_pkg::RB_VOLTAGE: begin
        pick_byte = (idx == 2'd0) ? v[11:4] : {v[3:0], 4'h0};
      end
      power_monitor_pkg::RB_CURRENT: begin
        pick_byte = (idx == 2'd0) ? i[11:4] : {i[3:0], 4'h0};
      end
      power_monitor_pkg::RB_STATUS: pick_byte = s;
    endcase
  endfunction

  // a read starts only from idle with the buffer drained
  wire startOk = rdStart && state_ff == power_monitor_pkg::SEQ_IDLE &&
                 !bufOutValid;
  wire pushByte = state_ff == power_monitor_pkg::SEQ_SEND && bufInReady;
  wire lastByte = byteIdx_ff == byte_total(mode_ff) - 2'd1;

  power_monitor_pkg::read_byte_t bufIn;
  assign bufIn.data = pick_byte(mode_ff, byteIdx_ff, snapV_ff, snapI_ff,
                                snapS_ff);
  assign bufIn.last = lastByte;

  // answer the address phase: nack while a single shot is pending
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ackValid_ff <= 1'b0;
      ackYes_ff <= 1'b0;
    end else begin
      ackValid_ff <= startOk;
      ackYes_ff <= startOk && !oncePending;
    end
  end
  assign rdAckValid = ackValid_ff;
  assign rdAckYes = ackYes_ff;

  // sequencer walks the bytes of the mode frozen at the start
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= power_monitor_pkg::SEQ_IDLE;
      mode_ff <= power_monitor_pkg::RB_COMBINED;
      byteIdx_ff <= 2'd0;
      snapV_ff <= 12'h000;
      snapI_ff <= 12'h000;
      snapS_ff <= 8'h00;
    end else if (rdStop) begin
      state_ff <= power_monitor_pkg::SEQ_IDLE;
    end else begin
      unique case (state_ff)
        power_monitor_pkg::SEQ_IDLE: begin
          if (startOk && !oncePending) begin
            state_ff <= power_monitor_pkg::SEQ_SEND;
            mode_ff <= modeNow;
            byteIdx_ff <= 2'd0;
            snapV_ff <= voltData_ff;
            snapI_ff <= currData_ff;
            snapS_ff <= statusLive;
          end
        end
        power_monitor_pkg::SEQ_SEND: begin
          if (pushByte) begin
            byteIdx_ff <= byteIdx_ff + 2'd1;
            if (lastByte) state_ff <= power_monitor_pkg::SEQ_IDLE;
          end
        end
      endcase
    end
  end

  // stall by the bus engine holds bytes here without loss
  two_entry_buffer #(
    .WIDTH($bits(power_monitor_pkg::read_byte_t))
  ) u_buffer (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .flush(rdStop),
    .inValid(pushByte),
    .inReady(bufInReady),
    .inData(bufIn),
    .outValid(bufOutValid),
    .outReady(byteReady),
    .outData(byteOut)
  );
  assign byteValid = bufOutValid;

  // -------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------
  sequence s_read_start;
    startOk && !oncePending;
  endsequence

  property p_threshold;
    @(posedge clk_sys) disable iff (!rst_b)
    currDone && currOver && alarmEnable_ff[0] |=> convAlarm_ff;
  endproperty
  a_threshold: assert property (p_threshold)
    else $error("conversion above threshold did not raise alarm");

  property p_force_off;
    @(posedge clk_sys) disable iff (!rst_b)
    $past(ctlWrite && cfgWrite.data[0]) && alarmEnable_ff[3] |-> alarmOe;
  endproperty
  a_force_off: assert property (p_force_off)
    else $error("alarm released while forced off");

  property p_combined_third;
    @(posedge clk_sys) disable iff (!rst_b)
    pushByte && mode_ff == power_monitor_pkg::RB_COMBINED && lastByte
      |-> byteIdx_ff == 2'd2 &&
          bufIn.data == {snapV_ff[3:0], snapI_ff[3:0]};
  endproperty
  a_combined_third: assert property (p_combined_third)
    else $error("combined third byte misplaced");

  property p_single_channel;
    @(posedge clk_sys) disable iff (!rst_b)
    pushByte && lastByte && (mode_ff == power_monitor_pkg::RB_VOLTAGE ||
      mode_ff == power_monitor_pkg::RB_CURRENT)
      |-> byteIdx_ff == 2'd1 && bufIn.data[3:0] == 4'h0;
  endproperty
  a_single_channel: assert property (p_single_channel)
    else $error("single channel read wrong length or nibble");

  property p_status_snap;
    @(posedge clk_sys) disable iff (!rst_b)
    s_read_start ##1 mode_ff == power_monitor_pkg::RB_STATUS
      |-> snapS_ff == $past(statusLive) ##1 (!pushByte || lastByte);
  endproperty
  a_status_snap: assert property (p_status_snap)
    else $error("status read not a single status byte");

  property p_clear;
    @(posedge clk_sys) disable iff (!rst_b)
    clearPulse && !convAlarmSet && !ocAlarmSet && !forceOffActive
      |=> !convAlarm_ff && !latchedOcAlarm_ff && !forceOffAlarm_ff;
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear left a sticky bit set");

  property p_delay;
    @(posedge clk_sys) disable iff (!rst_b)
    $rose(latchedOcAlarm_ff) |-> $past(tripCnt_ff) == TRIP_MAX;
  endproperty
  a_delay: assert property (p_delay)
    else $error("latched alarm before the delay ended");

  property p_nack_pending;
    @(posedge clk_sys) disable iff (!rst_b)
    startOk && oncePending |=> rdAckValid && !rdAckYes
      ##1 state_ff == power_monitor_pkg::SEQ_IDLE;
  endproperty
  a_nack_pending: assert property (p_nack_pending)
    else $error("read acknowledged during single shot");

endmodule

/* tb/byte_engine_model.sv */
// far-side byte engine model: pops read bytes and logs the last three
// assumes the bench pulses clrLog together with each read start
module byte_engine_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // control from the bench
  input wire logic stall,
  input wire logic clrLog,
  // byte stream from the block
  input wire logic byteValid,
  output logic byteReady,
  input wire power_monitor_pkg::read_byte_t byteOut,
  // log of taken bytes
  output logic [23:0] gotBytes,
  output logic [3:0] gotCount,
  output logic gotLast
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------
  // ready moves just after an edge, never on it
  // ---------------------------------------------------------
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) byteReady <= 1'b0;
    else byteReady <= #1 !stall;
  end
  // ---------------------------------------------------------
  // take bytes; log each one and whether it was flagged last
  // ---------------------------------------------------------
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      gotBytes <= 24'h000000;
      gotCount <= 4'h0;
      gotLast <= 1'b0;
    end else if (clrLog) begin
      gotBytes <= 24'h000000;
      gotCount <= 4'h0;
      gotLast <= 1'b0;
    end else if (byteValid && byteReady) begin
      gotBytes <= {gotBytes[15:0], byteOut.data};
      gotCount <= gotCount + 4'h1;
      gotLast <= byteOut.last;
    end
  end
endmodule

/* tb/testbench.sv */
// self-checking bench of the power monitor readback and alarm block
// assumes the byte engine model stands in for the bus engine
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TD = 8;  // short fault delay keeps runs brief
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic cfgValid = 1'b0;
  power_monitor_pkg::cfg_write_t cfgWrite = '0;
  logic convValid = 1'b0;
  logic convIsCurrent = 1'b0;
  logic [11:0] convCode = 12'h000;
  logic tripCompAbove = 1'b0;
  logic rdStart = 1'b0;
  logic stall = 1'b0;
  logic vCont, cCont, vOnce, cOnce, rdAckValid, rdAckYes, byteValid;
  logic byteReady, alarmOut, alarmOe, gotLast;
  power_monitor_pkg::read_byte_t byteOut;
  logic [23:0] gotBytes;
  logic [3:0] gotCount;
  wire alarmIn = !alarmOe;  // pull-up wins once the pin is released
  int n_mismatch = 0;
  int num_checks = 0;
  always #4 clk_sys = ~clk_sys;
  power_monitor_readback_alert #(.TRIP_DELAY(TD)) power_monitor_readback_alert_i (
    .clk_sys(clk_sys), .rst_b(rst_b), .cfgValid(cfgValid),
    .cfgWrite(cfgWrite), .convValid(convValid),
    .convIsCurrent(convIsCurrent), .convCode(convCode),
    .tripCompAbove(tripCompAbove), .voltageContinuous(vCont),
    .currentContinuous(cCont), .voltageOncePending(vOnce),
    .currentOncePending(cOnce), .rdStart(rdStart), .rdStop(1'b0),
    .rdAckValid(rdAckValid), .rdAckYes(rdAckYes), .byteValid(byteValid),
    .byteReady(byteReady), .byteOut(byteOut), .alarmOut(alarmOut),
    .alarmOe(alarmOe), .alarmIn(alarmIn));
  byte_engine_model byte_engine_model_i (
    .clk_sys(clk_sys), .rst_b(rst_b), .stall(stall), .clrLog(rdStart),
    .byteValid(byteValid), .byteReady(byteReady), .byteOut(byteOut),
    .gotBytes(gotBytes), .gotCount(gotCount), .gotLast(gotLast));
  // -----------------------------------------------------------
  // shared drivers and compare
  // -----------------------------------------------------------
  task automatic chk(input string nm, input logic [23:0] e,
                     input logic [23:0] g);
    num_checks++;
    if (e !== g) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic x, input logic [1:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    cfgValid = 1'b1;
    cfgWrite = {x, a, d};
    @(negedge clk_sys);
    cfgValid = 1'b0;
  endtask
  task automatic conv(input logic cur, input logic [11:0] c);
    @(negedge clk_sys);
    convValid = 1'b1;
    convIsCurrent = cur;
    convCode = c;
    @(negedge clk_sys);
    convValid = 1'b0;
  endtask
  // a stall of st cycles lets the buffer fill before draining
  task automatic rd(input logic ack, input logic [23:0] e, input int n,
                    input int st);
    int k;
    @(negedge clk_sys);
    stall = (st > 0);
    rdStart = 1'b1;
    @(negedge clk_sys);
    rdStart = 1'b0;
    for (k = 0; k < 10 && rdAckValid !== 1'b1; k++) @(negedge clk_sys);
    chk("rdAckYes", {23'h0, ack}, {23'h0, rdAckYes});
    repeat (st) @(negedge clk_sys);
    if (st > 0) chk("byteValid", 24'h1, {23'h0, byteValid});
    stall = 1'b0;
    for (k = 0; k < 20 && gotCount != 4'(n); k++) @(negedge clk_sys);
    @(negedge clk_sys);  // one more cycle exposes a surplus byte
    chk("bytes", e, gotBytes);
    chk("count", 24'(n), {20'h0, gotCount});
    if (n > 0) chk("last", 24'h1, {23'h0, gotLast});
  endtask
  task automatic oe(input logic e);
    chk("alarmOe", {23'h0, e}, {23'h0, alarmOe});
    chk("alarmOut", 24'h0, {23'h0, alarmOut});
  endtask
  // -----------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------
  task automatic t_readback();
    conv(1'b0, 12'habc);
    conv(1'b1, 12'h123);
    rd(1'b1, 24'hab12c3, 3, 6);
    wr(1'b0, 2'h0, 8'h01);
    chk("cont", 24'h2, {22'h0, vCont, cCont});
    rd(1'b1, 24'h00abc0, 2, 0);
    wr(1'b0, 2'h0, 8'h04);
    rd(1'b1, 24'h001230, 2, 0);
  endtask
  // a dropout one cycle short of the delay must restart the count
  task automatic t_trip();
    wr(1'b0, 2'h0, 8'h40);
    tripCompAbove = 1'b1;
    repeat (TD - 1) @(negedge clk_sys);
    tripCompAbove = 1'b0;
    @(negedge clk_sys);
    tripCompAbove = 1'b1;
    repeat (TD - 1) @(negedge clk_sys);
    oe(1'b1);
    @(negedge clk_sys);
    oe(1'b0);
    rd(1'b1, 24'h00000c, 1, 0);
    tripCompAbove = 1'b0;
    wr(1'b1, 2'h1, 8'h14);
    rd(1'b1, 24'h000000, 1, 0);
    oe(1'b1);
  endtask
  task automatic t_conv();
    wr(1'b1, 2'h2, 8'h40);
    wr(1'b1, 2'h1, 8'h05);
    conv(1'b1, 12'h410);
    oe(1'b0);
    rd(1'b1, 24'h000002, 1, 0);
    conv(1'b1, 12'h410);
    conv(1'b1, 12'h410);
    rd(1'b1, 24'h000003, 1, 0);
    conv(1'b1, 12'h40f);
    rd(1'b1, 24'h000002, 1, 0);
    wr(1'b1, 2'h1, 8'h15);
    rd(1'b1, 24'h000000, 1, 0);
    oe(1'b1);
  endtask
  task automatic t_force();
    wr(1'b1, 2'h1, 8'h0c);
    wr(1'b1, 2'h3, 8'h01);
    tripCompAbove = 1'b1;
    repeat (TD + 2) @(negedge clk_sys);
    oe(1'b1);
    rd(1'b1, 24'h00003c, 1, 0);
    tripCompAbove = 1'b0;
    wr(1'b1, 2'h3, 8'h00);
    wr(1'b1, 2'h1, 8'h14);
    rd(1'b1, 24'h000000, 1, 0);
  endtask
  task automatic t_once();
    wr(1'b0, 2'h0, 8'h02);
    chk("once", 24'h2, {22'h0, vOnce, cOnce});
    rd(1'b0, 24'h000000, 0, 0);
    conv(1'b0, 12'h5a7);
    chk("vOnce", 24'h0, {23'h0, vOnce});
    rd(1'b1, 24'h005a70, 2, 0);
  endtask
  // -----------------------------------------------------------
  // verdict, main sequence and watchdog
  // -----------------------------------------------------------
  task automatic tally_and_finish();
    if (n_mismatch == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge clk_sys);
    rst_b = 1'b1;
    oe(1'b1);
    wr(1'b0, 2'h0, 8'h05);
    rd(1'b1, 24'h000000, 3, 0);
    t_readback();
    t_trip();
    t_conv();
    t_force();
    t_once();
    tally_and_finish();
  end
  initial begin
    #100000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule
